// ==== flash_addr_pkg.sv ====
// Purpose: Shared constants and types for the flash address-width front end
// Assumes: Serial pins are sampled by the system clock, MSB first, mode 0
// Notes:   Opcode values select command classes only; the full command set lives elsewhere
package flash_addr_pkg;

    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned SYNC_W      = 3;

    // Synchroniser lane positions
    localparam int unsigned LANE_SCK    = 0;
    localparam int unsigned LANE_CS     = 1;
    localparam int unsigned LANE_SI     = 2;

    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam logic [1:0] SHORT_LAST   = 2'h2;
    localparam logic [1:0] LONG_LAST    = 2'h3;
    localparam logic [7:0] UPPER_ZERO   = 8'h00;
    localparam logic       EXT_RST      = 1'b0;

    // Mode change commands
    localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
    localparam logic [7:0] OP_EXIT_WIDE  = 8'he9;
    // Original commands carrying an address
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_FAST_READ  = 8'h0b;
    localparam logic [7:0] OP_PROGRAM    = 8'h02;
    localparam logic [7:0] OP_ERASE_BLK  = 8'hd8;
    localparam logic [7:0] OP_ERASE_PAR  = 8'h20;
    // Dedicated wide-address commands
    localparam logic [7:0] OP_READ_W     = 8'h13;
    localparam logic [7:0] OP_FAST_W     = 8'h0c;
    localparam logic [7:0] OP_PROGRAM_W  = 8'h12;
    localparam logic [7:0] OP_ERASE_BLKW = 8'hdc;
    localparam logic [7:0] OP_ERASE_PARW = 8'h21;
    // Commands aimed at spaces outside the main array
    localparam logic [7:0] OP_READ_ANY   = 8'h65;
    localparam logic [7:0] OP_READ_OTP   = 8'h4b;

    typedef enum logic [1:0] {
        ST_CMD  = 2'b00,
        ST_ADDR = 2'b01,
        ST_SKIP = 2'b10
    } state_t;

    typedef enum logic [1:0] {
        CL_NONE   = 2'b00,
        CL_LEGACY = 2'b01,
        CL_WIDE   = 2'b10,
        CL_OTHER  = 2'b11
    } cmdClass_t;

    function automatic cmdClass_t cmdClass(input logic [7:0] op);
        case (op)
            OP_READ, OP_FAST_READ, OP_PROGRAM, OP_ERASE_BLK, OP_ERASE_PAR: cmdClass = CL_LEGACY;
            OP_READ_W, OP_FAST_W, OP_PROGRAM_W, OP_ERASE_BLKW, OP_ERASE_PARW: cmdClass = CL_WIDE;
            OP_READ_ANY, OP_READ_OTP: cmdClass = CL_OTHER;
            default: cmdClass = CL_NONE;
        endcase
    endfunction

endpackage

// ==== serial_byte_if.sv ====
// Purpose: Byte stream from the serial receiver to the command front end
// Assumes: One clock domain
// Notes:   byteValid is a one-cycle pulse
`timescale 1ns/1ns
interface serial_byte_if;
    logic       byteValid;
    logic [7:0] byteData;
    logic       frameActive;

    modport rx  (output byteValid, output byteData, output frameActive);
    modport cmd (input byteValid, input byteData, input frameActive);
endinterface

// ==== serial_byte_rx.sv ====
// Purpose: Sample the serial pins and assemble bytes within a select frame
// Assumes: Serial clock well below a quarter of the system clock
// Notes:   All pins pass two flip-flops before any logic sees them
`timescale 1ns/1ns
module serial_byte_rx
    import flash_addr_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    sys_rst,
    input  wire logic    sck,
    input  wire logic    csN,
    input  wire logic    si,
    serial_byte_if.rx    bl
);
    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    logic              sckPrev_r;
    logic              sckPrev_nxt;
    logic [2:0]        bitCnt_r;
    logic [2:0]        bitCnt_nxt;
    logic [7:0]        shift_r;
    logic [7:0]        shift_nxt;
    logic              valid_r;
    logic              valid_nxt;
    logic              active;
    logic              sckRise;

    assign active  = ~sync_r[LANE_CS];
    assign sckRise = sync_r[LANE_SCK] & ~sckPrev_r;

    always_comb begin
        sckPrev_nxt = sync_r[LANE_SCK];
        bitCnt_nxt  = bitCnt_r;
        shift_nxt   = shift_r;
        valid_nxt   = 1'b0;
        if (!active) begin
            // A frame cut short drops its partial byte
            bitCnt_nxt = 3'h0;
        end else if (sckRise) begin
            shift_nxt  = {shift_r[6:0], sync_r[LANE_SI]};
            bitCnt_nxt = bitCnt_r + 3'h1;
            valid_nxt  = (bitCnt_r == BIT_LAST);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r    <= '1;
            sync_r    <= '1;
            sckPrev_r <= 1'b1;
            bitCnt_r  <= 3'h0;
            shift_r   <= 8'h00;
            valid_r   <= 1'b0;
        end else begin
            meta_r    <= {si, csN, sck};
            sync_r    <= meta_r;
            sckPrev_r <= sckPrev_nxt;
            bitCnt_r  <= bitCnt_nxt;
            shift_r   <= shift_nxt;
            valid_r   <= valid_nxt;
        end
    end

    assign bl.byteValid   = valid_r;
    assign bl.byteData    = shift_r;
    assign bl.frameActive = active;
endmodule

// ==== flash_address_width_select.sv ====
// Purpose: Decide 24- or 32-bit address per command and assemble the address
// Assumes: nvExtDefault is held stable by the non-volatile store
// Notes:   Mode change takes effect from the command byte of the next frame
`timescale 1ns/1ns
module flash_address_width_select
    import flash_addr_pkg::*;
#(
    parameter bit SMALL_DENSITY = 1'b0
)
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 sck,
    input  wire logic                 csN,
    input  wire logic                 si,
    input  wire logic                 nvExtDefault,
    output logic [7:0]                cmdCode_r,
    output logic [flash_addr_pkg::ADDR_W-1:0] addrOut_r,
    output logic                      addrValid_r,
    output logic                      addrWide_r,
    output logic                      otherSpace_r,
    output logic                      extAddrMode_r
);
    serial_byte_if bl();

    serial_byte_rx u_rx (
        .clock   (clock),
        .sys_rst (sys_rst),
        .sck     (sck),
        .csN     (csN),
        .si      (si),
        .bl      (bl.rx)
    );

    state_t      state_r;
    state_t      state_nxt;
    logic [1:0]  byteCnt_r;
    logic [1:0]  byteCnt_nxt;
    logic [23:0] shift_r;
    logic [23:0] shift_nxt;
    logic        loadPend_r;
    logic [7:0]  cmdCode_nxt;
    logic [ADDR_W-1:0] addrOut_nxt;
    logic        addrValid_nxt;
    logic        addrWide_nxt;
    logic        otherSpace_nxt;
    logic        extAddrMode_nxt;
    cmdClass_t   cls;
    logic [1:0]  lastIdx;
    logic [ADDR_W-1:0] full;

    assign cls     = cmdClass(bl.byteData);
    assign lastIdx = addrWide_r ? LONG_LAST : SHORT_LAST;

    always_comb begin
        state_nxt       = state_r;
        byteCnt_nxt     = byteCnt_r;
        shift_nxt       = shift_r;
        cmdCode_nxt     = cmdCode_r;
        addrOut_nxt     = addrOut_r;
        addrValid_nxt   = 1'b0;
        addrWide_nxt    = addrWide_r;
        otherSpace_nxt  = otherSpace_r;
        extAddrMode_nxt = extAddrMode_r;
        full            = '0;
        if (loadPend_r) begin
            extAddrMode_nxt = nvExtDefault;
        end
        if (!bl.frameActive) begin
            state_nxt   = ST_CMD;
            byteCnt_nxt = 2'h0;
        end else if (bl.byteValid) begin
            case (state_r)
                ST_CMD: begin
                    cmdCode_nxt    = bl.byteData;
                    byteCnt_nxt    = 2'h0;
                    shift_nxt      = 24'h000000;
                    otherSpace_nxt = (cls == CL_OTHER);
                    // Wide commands ignore the mode; others follow it
                    addrWide_nxt   = (cls == CL_WIDE) | extAddrMode_r;
                    state_nxt      = (cls == CL_NONE) ? ST_SKIP : ST_ADDR;
                    if (bl.byteData == OP_ENTER_WIDE) begin
                        extAddrMode_nxt = 1'b1;
                    end else if (bl.byteData == OP_EXIT_WIDE) begin
                        extAddrMode_nxt = 1'b0;
                    end
                end
                ST_ADDR: begin
                    shift_nxt   = {shift_r[15:0], bl.byteData};
                    byteCnt_nxt = byteCnt_r + 2'h1;
                    if (byteCnt_r == lastIdx) begin
                        if (addrWide_r) begin
                            full = {shift_r, bl.byteData};
                        end else begin
                            full = {UPPER_ZERO, shift_r[15:0], bl.byteData};
                        end
                        // Only the main array drops the top byte on the small part
                        if (SMALL_DENSITY && !otherSpace_r) begin
                            full[31:24] = UPPER_ZERO;
                        end
                        addrOut_nxt   = full;
                        addrValid_nxt = 1'b1;
                        state_nxt     = ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    state_nxt = ST_SKIP;
                end
                default: begin
                    state_nxt = ST_CMD;
                end
            endcase
        end
    end

    // The default bit is a port, so it is caught one edge after release
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r       <= ST_CMD;
            byteCnt_r     <= 2'h0;
            shift_r       <= 24'h000000;
            loadPend_r    <= 1'b1;
            cmdCode_r     <= 8'h00;
            addrOut_r     <= '0;
            addrValid_r   <= 1'b0;
            addrWide_r    <= 1'b0;
            otherSpace_r  <= 1'b0;
            extAddrMode_r <= EXT_RST;
        end else begin
            state_r       <= state_nxt;
            byteCnt_r     <= byteCnt_nxt;
            shift_r       <= shift_nxt;
            loadPend_r    <= 1'b0;
            cmdCode_r     <= cmdCode_nxt;
            addrOut_r     <= addrOut_nxt;
            addrValid_r   <= addrValid_nxt;
            addrWide_r    <= addrWide_nxt;
            otherSpace_r  <= otherSpace_nxt;
            extAddrMode_r <= extAddrMode_nxt;
        end
    end

    sequence sCmdTaken;
        bl.frameActive && bl.byteValid && state_r == ST_CMD;
    endsequence

    sequence sLastByte;
        bl.frameActive && bl.byteValid && state_r == ST_ADDR;
    endsequence

    // Keyed on the load flag falling: the edge that releases reset still clocks the reset branch
    a_nv_default_load: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(loadPend_r) |-> extAddrMode_r == $past(nvExtDefault))
        else $error("Extended mode not loaded from default bit");

    a_wide_cmd_width: assert property (
        @(posedge clock) disable iff (sys_rst)
        sCmdTaken and (cls == CL_WIDE) |=> addrWide_r && state_r == ST_ADDR)
        else $error("Wide command did not select 32-bit address");

    a_legacy_follows_mode: assert property (
        @(posedge clock) disable iff (sys_rst)
        sCmdTaken and (cls == CL_LEGACY) |=> addrWide_r == $past(extAddrMode_r))
        else $error("Original command width does not follow mode");

    a_other_space_width: assert property (
        @(posedge clock) disable iff (sys_rst)
        sCmdTaken and (cls == CL_OTHER)
            |=> otherSpace_r && addrWide_r == $past(extAddrMode_r))
        else $error("Other-space command width wrong");

    a_long_addr_bytes: assert property (
        @(posedge clock) disable iff (sys_rst)
        sLastByte and (byteCnt_r == LONG_LAST)
            |=> addrValid_r && addrOut_r[7:0] == $past(bl.byteData))
        else $error("Fourth address byte did not complete address");

    a_short_addr_bytes: assert property (
        @(posedge clock) disable iff (sys_rst)
        addrValid_r |-> $past(byteCnt_r) == (addrWide_r ? LONG_LAST : SHORT_LAST))
        else $error("Address completed after wrong byte count");

    a_short_upper_zero: assert property (
        @(posedge clock) disable iff (sys_rst)
        addrValid_r && !addrWide_r |-> addrOut_r[31:24] == UPPER_ZERO)
        else $error("Short address upper byte not zero");

    a_small_density_top: assert property (
        @(posedge clock) disable iff (sys_rst)
        SMALL_DENSITY && addrValid_r && !otherSpace_r |-> addrOut_r[31:24] == UPPER_ZERO)
        else $error("Top address byte used on small density");

    a_short_reach: assert property (
        @(posedge clock) disable iff (sys_rst)
        addrValid_r && !addrWide_r |-> addrOut_r < 32'h01000000)
        else $error("Short address beyond 16 MB");

    a_valid_one_pulse: assert property (
        @(posedge clock) disable iff (sys_rst)
        addrValid_r |=> !addrValid_r [*2])
        else $error("Address valid longer than one cycle");
endmodule

// ==== flash_host_model.sv ====
// Purpose: Host controller model that drives the serial pins of the flash front end
// Assumes: Mode 0, MSB first, serial clock idle low outside frames
// Notes:   Between frames the model drives the data line to the inverse of its last bit
`timescale 1ns/1ns
module flash_host_model (
    input  wire logic clock,
    output logic      sck,
    output logic      csN,
    output logic      si
);
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        si  = 1'b0;
    end

    task automatic waitCycles(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Command byte, then nBytes address bytes MSB first; half sets each sck phase
    task automatic sendFrame(input logic [7:0] op, input logic [31:0] addr,
                             input int nBytes, input int half);
        logic [39:0] bits;
        int          n;
        bits = {op, addr << (8 * (4 - nBytes))};
        n    = 8 * (nBytes + 1);
        @(posedge clock);
        csN <= 1'b0;
        for (int i = 0; i < n; i++) begin
            waitCycles(half);
            sck <= 1'b0;
            si  <= bits[39-i];
            waitCycles(half);
            sck <= 1'b1;
        end
        waitCycles(half);
        sck <= 1'b0;
        waitCycles(half);
        csN <= 1'b1;
        si  <= ~si;
        // Deselect gap kept above the three-cycle minimum
        waitCycles(5);
    endtask
endmodule

// ==== test_flash_address_width_select.sv ====
// Purpose: Self-checking bench for the address width front end
// Assumes: Host model drives the pins; two instances cover both densities
// Notes:   Expected completions are queued by the bench before each frame
`timescale 1ns/1ns
module test_flash_address_width_select;
    import flash_addr_pkg::*;

    typedef struct packed {
        logic [7:0]  op;
        logic [31:0] addr;
        logic [31:0] addrSmall;
        logic        wide;
        logic        other;
    } expect_t;

    logic        clock;
    logic        sys_rst;
    logic        nvExtDefault;
    logic        sck;
    logic        csN;
    logic        si;
    logic [7:0]  cmdCode;
    logic [31:0] addrOut;
    logic [31:0] addrSmall;
    logic        addrValid;
    logic        validSmall;
    logic        addrWide;
    logic        otherSpace;
    logic        extAddrMode;
    expect_t     expQ [$];
    expect_t     cur;
    int          extMode;
    int          n_fail;
    int          n_compared;
    logic [7:0]  ops [12] = '{OP_READ, OP_FAST_READ, OP_PROGRAM, OP_ERASE_BLK, OP_ERASE_PAR,
        OP_READ_W, OP_FAST_W, OP_PROGRAM_W, OP_ERASE_BLKW, OP_ERASE_PARW, OP_READ_ANY, OP_READ_OTP};

    flash_host_model host (.clock(clock), .sck(sck), .csN(csN), .si(si));

    flash_address_width_select #(.SMALL_DENSITY(1'b0)) dut (
        .clock(clock), .sys_rst(sys_rst), .sck(sck), .csN(csN), .si(si),
        .nvExtDefault(nvExtDefault), .cmdCode_r(cmdCode), .addrOut_r(addrOut),
        .addrValid_r(addrValid), .addrWide_r(addrWide), .otherSpace_r(otherSpace),
        .extAddrMode_r(extAddrMode));

    flash_address_width_select #(.SMALL_DENSITY(1'b1)) dutSmall (
        .clock(clock), .sys_rst(sys_rst), .sck(sck), .csN(csN), .si(si),
        .nvExtDefault(nvExtDefault), .cmdCode_r(), .addrOut_r(addrSmall),
        .addrValid_r(validSmall), .addrWide_r(), .otherSpace_r(), .extAddrMode_r());

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // 1 original, 2 dedicated wide, 3 other space
    function automatic int opKind(input logic [7:0] op);
        foreach (ops[i]) if (ops[i] === op) return (i < 5) ? 1 : (i < 10) ? 2 : 3;
        return 0;
    endfunction

    task automatic runOp(input logic [7:0] op);
        expect_t     e;
        int          k;
        int          nb;
        logic [31:0] a;
        k           = opKind(op);
        a           = $urandom;
        nb          = (k == 2 || extMode == 1) ? 4 : 3;
        e.op        = op;
        e.wide      = (nb == 4);
        e.other     = (k == 3);
        e.addr      = (nb == 4) ? a : {UPPER_ZERO, a[23:0]};
        e.addrSmall = e.other ? e.addr : {UPPER_ZERO, e.addr[23:0]};
        expQ.push_back(e);
        host.sendFrame(op, a, nb, 3 + $urandom % 4);
    endtask

    task automatic setMode(input logic [7:0] op, input int m);
        host.sendFrame(op, 32'h0, 0, 3);
        extMode = m;
        check("extAddrMode_r", extMode, extAddrMode);
    endtask

    task automatic doReset(input logic nv);
        @(posedge clock);
        nvExtDefault <= nv;
        sys_rst      <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        extMode = nv;
        check("extAddrMode_r", nv, extAddrMode);
    endtask

    // Every completion pulse is matched against the oldest queued expectation
    always @(negedge clock) begin
        if (addrValid === 1'b1 || validSmall === 1'b1) begin
            if (expQ.size() == 0) begin
                $display("wrong value addrValid_r expected 0 seen 1");
                n_fail++;
            end else begin
                cur = expQ.pop_front();
                check("addrValid_r", 1, addrValid);
                check("addrValid_r small", 1, validSmall);
                check("cmdCode_r", cur.op, cmdCode);
                check("addrOut_r", cur.addr, addrOut);
                check("addrOut_r small", cur.addrSmall, addrSmall);
                check("addrWide_r", cur.wide, addrWide);
                check("otherSpace_r", cur.other, otherSpace);
            end
        end
    end

    initial begin
        #600000;
        n_fail++;
        $display("wrong value watchdog expected finish seen timeout");
        give_verdict();
    end

    initial begin
        sys_rst      = 1'b1;
        nvExtDefault = 1'b0;
        n_fail       = 0;
        n_compared   = 0;
        extMode      = 0;
        void'($urandom(89401));
        doReset(1'b0);
        foreach (ops[i]) runOp(ops[i]);
        // Unknown opcode and a cut-short address must both stay silent
        host.sendFrame(8'h9f, $urandom, 3, 3);
        host.sendFrame(OP_READ, $urandom, 2, 4);
        setMode(OP_ENTER_WIDE, 1);
        foreach (ops[i]) runOp(ops[i]);
        setMode(OP_EXIT_WIDE, 0);
        runOp(OP_READ_ANY);
        doReset(1'b1);
        foreach (ops[i]) runOp(ops[i]);
        doReset(1'b0);
        runOp(OP_ERASE_PAR);
        check("pending completions", 0, expQ.size());
        give_verdict();
    end
endmodule
